// *** verilog/dma_err_pkg.sv ***
// Purpose: Shared constants for the DMA TLP error logger
// Assumes: One 100 MHz core clock, AHB-Lite register access
// Notes: Byte offsets are word aligned
package dma_err_pkg;
    localparam int NUM_CH = 4;
    localparam int NUM_FUNC = 2;
    localparam int ADDR_W = 8;
    localparam int HDR_WORDS = 4;
    localparam int CNT_W = 16;

    // Completion status codes
    localparam logic [2:0] CPL_STS_UR = 3'h1;
    localparam logic [2:0] CPL_STS_CA = 3'h4;

    // Channel error flag positions
    localparam int CH_DESC_UR = 0;
    localparam int CH_DATA_UR = 1;
    localparam int CH_DESC_CA = 2;
    localparam int CH_DATA_CA = 3;

    // Received error vector positions; AER_TIMEOUT is an AER status bit only
    localparam int RX_INTERNAL = 0;
    localparam int RX_OVERFLOW = 1;
    localparam int RX_ECRC = 2;
    localparam int RX_MALFORMED = 3;
    localparam int RX_UNSUP = 4;
    localparam int RX_UNEXP_CPL = 5;
    localparam int RX_POISON = 6;
    localparam int AER_TIMEOUT = 7;

    // Legacy status and interrupt fields
    localparam int PCI_PARITY_BIT = 15;
    localparam int IRQ_AER_BIT = 4;
    localparam int IRQ_PARITY_BIT = 5;

    // Register byte offsets
    localparam logic [7:0] OFS_CH_ERR0 = 8'h00;
    localparam logic [7:0] OFS_AER_STS = 8'h10;
    localparam logic [7:0] OFS_HDR0 = 8'h14;
    localparam logic [7:0] OFS_PCI_STS = 8'h24;
    localparam logic [7:0] OFS_IRQ_STS = 8'h28;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h2c;
    localparam logic [7:0] OFS_TO_CNT = 8'h30;
    localparam logic [7:0] OFS_CH_RUN = 8'h34;

    localparam logic [31:0] RST_WORD = 32'h0;
    localparam logic [31:0] HDR_ALL_ONES = 32'hffffffff;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_POISON = 3'b001,
        SEL_URUC = 3'b010,
        SEL_MALF = 3'b011,
        SEL_ECRC = 3'b100,
        SEL_OVFL = 3'b101,
        SEL_INTERNAL = 3'b110
    } err_sel_t;
endpackage

// *** verilog/chan_err_if.sv ***
// Purpose: Carrier between logger top and channel tracker
// Assumes: All signals on core_clk
// Notes: Flags are per channel, four bits each
`timescale 1ns/100ps
interface chan_err_if;
    import dma_err_pkg::*;
    logic cpl_valid;
    logic cpl_expected;
    logic cpl_is_desc;
    logic [1:0] cpl_chan;
    logic [2:0] cpl_status;
    logic [NUM_CH-1:0] start;
    logic [NUM_CH-1:0][3:0] clr;
    logic [NUM_CH-1:0][3:0] flags;
    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] abort;
    modport top (output cpl_valid, cpl_expected, cpl_is_desc, cpl_chan,
                 cpl_status, start, clr, input flags, run, abort);
    modport trk (input cpl_valid, cpl_expected, cpl_is_desc, cpl_chan,
                 cpl_status, start, clr, output flags, run, abort);
endinterface

// *** verilog/chan_err_tracker.sv ***
// Purpose: Per-channel completion error flags and abort
// Assumes: Completion qualifiers come from same-clock logic
// Notes: Set wins over a software clear in the same cycle
`timescale 1ns/100ps
module chan_err_tracker
    import dma_err_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    chan_err_if.trk ch
);
    // =============================================
    // Per channel state
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [3:0] flags_q, flags_d, hit;
        logic run_q, run_d, abort_q, abort_d, mine;

        always_comb begin
            mine = ch.cpl_valid && ch.cpl_expected && ch.run[i]
                   && (ch.cpl_chan == 2'(i));
            hit = 4'h0;
            hit[CH_DESC_UR] = mine && ch.cpl_is_desc
                              && ch.cpl_status == CPL_STS_UR;
            hit[CH_DATA_UR] = mine && !ch.cpl_is_desc
                              && ch.cpl_status == CPL_STS_UR;
            hit[CH_DESC_CA] = mine && ch.cpl_is_desc
                              && ch.cpl_status == CPL_STS_CA;
            hit[CH_DATA_CA] = mine && !ch.cpl_is_desc
                              && ch.cpl_status == CPL_STS_CA;
            flags_d = (flags_q & ~ch.clr[i]) | hit;
            abort_d = |hit;
            run_d = abort_d ? 1'b0 : (run_q | ch.start[i]);
        end

        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                flags_q <= 4'h0;
                run_q <= 1'b0;
                abort_q <= 1'b0;
            end else if (ce) begin
                flags_q <= flags_d;
                run_q <= run_d;
                abort_q <= abort_d;
            end
        end

        assign ch.flags[i] = flags_q;
        assign ch.run[i] = run_q;
        assign ch.abort[i] = abort_q;

        a_ur_desc_stop: assert property (
            @(posedge core_clk) disable iff (!rstn)
            ce && hit[CH_DESC_UR] |=> flags_q[CH_DESC_UR] && !run_q && abort_q)
            else $error("UR on descriptor fetch did not stop channel");
        a_flag_sticky: assert property (
            @(posedge core_clk) disable iff (!rstn)
            ce && flags_q[CH_DATA_CA] && !ch.clr[i][CH_DATA_CA]
            |=> flags_q[CH_DATA_CA])
            else $error("Data abort flag dropped without clear");
        a_ca_data_set: assert property (
            @(posedge core_clk) disable iff (!rstn)
            ce && mine && !ch.cpl_is_desc && ch.cpl_status == CPL_STS_CA
            |=> flags_q[CH_DATA_CA] ##1 (!abort_q || !ce))
            else $error("Data abort flag or abort pulse wrong");
    end
endmodule

// *** verilog/aer_err_ranker.sv ***
// Purpose: Picks the reported error of one received packet
// Assumes: One packet's error vector presented at a time
// Notes: Pure logic; the top registers its result
`timescale 1ns/100ps
module aer_err_ranker
    import dma_err_pkg::*;
(
    input wire logic [6:0] err,
    input wire logic on_up_link,
    input wire logic from_link,
    input wire logic claimed_dma,
    input wire logic claimed_any,
    output err_sel_t sel,
    output logic log_hdr,
    output logic all_ones
);
    // =============================================
    // Fixed ranking, lower ranks suppressed
    always_comb begin
        sel = SEL_NONE;
        log_hdr = 1'b0;
        all_ones = 1'b0;
        if (err[RX_INTERNAL]) begin
            sel = SEL_INTERNAL;
            log_hdr = 1'b1;
            all_ones = 1'b1;
        end else if (err[RX_OVERFLOW]) begin
            sel = SEL_OVFL;
        end else if (err[RX_ECRC]) begin
            sel = SEL_ECRC;
            log_hdr = on_up_link;
        end else if (err[RX_MALFORMED]) begin
            sel = SEL_MALF;
            log_hdr = on_up_link;
        end else if (err[RX_UNSUP] || err[RX_UNEXP_CPL]) begin
            sel = SEL_URUC;
            log_hdr = claimed_dma
                      || (on_up_link && !claimed_any);
        end else if (err[RX_POISON]) begin
            sel = SEL_POISON;
            log_hdr = claimed_dma && on_up_link && from_link;
        end
    end
endmodule

// *** verilog/dma_tlp_error_logger.sv ***
// Purpose: Transaction-layer error logging for the DMA function
// Assumes: Event inputs come from same-clock logic, one cycle pulses
// Notes: AHB-Lite slave with zero wait states, always OKAY
`timescale 1ns/100ps
module dma_tlp_error_logger
    import dma_err_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Completions for channel reads
    input wire logic cpl_valid,
    input wire logic cpl_expected,
    input wire logic cpl_is_desc,
    input wire logic [1:0] cpl_chan,
    input wire logic [2:0] cpl_status,
    // Received packet errors
    input wire logic rx_valid,
    input wire logic [6:0] rx_err,
    input wire logic [127:0] rx_hdr,
    input wire logic rx_on_up_link,
    input wire logic rx_from_link,
    input wire logic rx_claimed_dma,
    input wire logic rx_claimed_any,
    input wire logic port_malformed,
    input wire logic cpl_timeout,
    // Results
    output logic [NUM_CH-1:0] chan_run,
    output logic [NUM_CH-1:0] chan_abort,
    output logic [NUM_FUNC-1:0] func_malformed,
    output logic irq
);
    // =============================================
    // Channel tracker
    chan_err_if ch ();
    err_sel_t sel;
    logic log_hdr, all_ones;

    chan_err_tracker u_trk (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .ch(ch)
    );

    aer_err_ranker u_rank (
        .err(rx_valid ? rx_err : 7'h0),
        .on_up_link(rx_on_up_link),
        .from_link(rx_from_link),
        .claimed_dma(rx_claimed_dma),
        .claimed_any(rx_claimed_any),
        .sel(sel),
        .log_hdr(log_hdr),
        .all_ones(all_ones)
    );

    // =============================================
    // Bus state
    logic wr_pend_q, wr_pend_d;
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic take;
    logic [31:0] rd_word;

    // =============================================
    // Error state
    logic [7:0] aer_q, aer_d, aer_set;
    logic hdr_vld_q, hdr_vld_d;
    logic [HDR_WORDS-1:0][31:0] hdr_q, hdr_d;
    logic [31:0] pci_q, pci_d;
    logic [5:0] isr_q, isr_d, imsk_q, imsk_d, isr_set;
    logic [CNT_W-1:0] to_cnt_q, to_cnt_d;
    logic [NUM_FUNC-1:0] fmal_q, fmal_d;
    logic irq_q, irq_d;
    logic [NUM_CH-1:0] abort_q;
    logic wr_hit;
    logic hdr_free;
    logic [31:0] wd;

    assign take = hsel && htrans[1] && hready;
    assign wd = hwdata;

    always_comb begin
        case (haddr)
            OFS_CH_ERR0: rd_word = {28'h0, ch.flags[0]};
            OFS_CH_ERR0 + 8'h04: rd_word = {28'h0, ch.flags[1]};
            OFS_CH_ERR0 + 8'h08: rd_word = {28'h0, ch.flags[2]};
            OFS_CH_ERR0 + 8'h0c: rd_word = {28'h0, ch.flags[3]};
            OFS_AER_STS: rd_word = {24'h0, aer_q};
            OFS_HDR0: rd_word = hdr_q[0];
            OFS_HDR0 + 8'h04: rd_word = hdr_q[1];
            OFS_HDR0 + 8'h08: rd_word = hdr_q[2];
            OFS_HDR0 + 8'h0c: rd_word = hdr_q[3];
            OFS_PCI_STS: rd_word = pci_q;
            OFS_IRQ_STS: rd_word = {26'h0, isr_q};
            OFS_IRQ_MSK: rd_word = {26'h0, imsk_q};
            OFS_TO_CNT: rd_word = {16'h0, to_cnt_q};
            OFS_CH_RUN: rd_word = {28'h0, ch.run};
            default: rd_word = RST_WORD;
        endcase
    end

    // Data for a read is latched at the address phase edge
    always_comb begin
        wr_pend_d = take && hwrite && hsize == 3'h2;
        wr_addr_d = take ? haddr : wr_addr_q;
        hrdata_d = (take && !hwrite) ? rd_word : RST_WORD;
    end

    // =============================================
    // Channel glue
    always_comb begin
        ch.cpl_valid = cpl_valid;
        ch.cpl_expected = cpl_expected;
        ch.cpl_is_desc = cpl_is_desc;
        ch.cpl_chan = cpl_chan;
        ch.cpl_status = cpl_status;
        ch.start = '0;
        ch.clr = '0;
        if (wr_pend_q && wr_addr_q == OFS_CH_RUN) begin
            ch.start = wd[NUM_CH-1:0];
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (wr_pend_q && wr_addr_q == OFS_CH_ERR0 + 8'(4 * i)) begin
                ch.clr[i] = wd[3:0];
            end
        end
    end

    // =============================================
    // Error logging
    always_comb begin
        aer_set = 8'h0;
        case (sel)
            SEL_INTERNAL: aer_set[RX_INTERNAL] = 1'b1;
            SEL_OVFL: aer_set[RX_OVERFLOW] = 1'b1;
            SEL_ECRC: aer_set[RX_ECRC] = 1'b1;
            SEL_MALF: aer_set[RX_MALFORMED] = 1'b1;
            SEL_URUC: begin
                aer_set[RX_UNSUP] = rx_err[RX_UNSUP];
                aer_set[RX_UNEXP_CPL] = rx_err[RX_UNEXP_CPL];
            end
            SEL_POISON: aer_set[RX_POISON] = 1'b1;
            default: aer_set = 8'h0;
        endcase
        aer_set[AER_TIMEOUT] = cpl_timeout;
        wr_hit = wr_pend_q && wr_addr_q == OFS_AER_STS;
        // Full clear and new error together: the new header wins
        hdr_free = (aer_q & ~(wr_hit ? wd[7:0] : 8'h0)) == 8'h0;
        aer_d = (aer_q & ~(wr_hit ? wd[7:0] : 8'h0)) | aer_set;
        to_cnt_d = to_cnt_q + CNT_W'(cpl_timeout);
        hdr_vld_d = hdr_vld_q;
        hdr_d = hdr_q;
        if (log_hdr && (!hdr_vld_q || hdr_free)) begin
            hdr_vld_d = 1'b1;
            for (int w = 0; w < HDR_WORDS; w++) begin
                hdr_d[w] = all_ones ? HDR_ALL_ONES : rx_hdr[32 * w +: 32];
            end
        end else if (aer_d == 8'h0) begin
            hdr_vld_d = 1'b0;
        end
        pci_d = pci_q;
        if (wr_pend_q && wr_addr_q == OFS_PCI_STS && wd[PCI_PARITY_BIT]) begin
            pci_d[PCI_PARITY_BIT] = 1'b0;
        end
        if (rx_valid && rx_err[RX_POISON]) begin
            pci_d[PCI_PARITY_BIT] = 1'b1;
        end
        // Only the port's ingress check feeds this; egress is unchecked
        fmal_d = {NUM_FUNC{port_malformed}};
        isr_set = {|aer_set[6:0], rx_valid && rx_err[RX_POISON],
                   ch.abort};
        isr_set = {isr_set[5], isr_set[4], isr_set[3:0]};
        isr_d = (isr_q & ~((wr_pend_q && wr_addr_q == OFS_IRQ_STS)
                 ? wd[5:0] : 6'h0)) | {isr_set[4], isr_set[5], isr_set[3:0]};
        imsk_d = (wr_pend_q && wr_addr_q == OFS_IRQ_MSK) ? wd[5:0] : imsk_q;
        irq_d = |(isr_d & imsk_d);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata_q <= RST_WORD;
            aer_q <= 8'h0;
            hdr_vld_q <= 1'b0;
            hdr_q <= '0;
            pci_q <= RST_WORD;
            isr_q <= 6'h0;
            imsk_q <= 6'h0;
            to_cnt_q <= '0;
            fmal_q <= '0;
            irq_q <= 1'b0;
            abort_q <= '0;
        end else if (ce) begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
            aer_q <= aer_d;
            hdr_vld_q <= hdr_vld_d;
            hdr_q <= hdr_d;
            pci_q <= pci_d;
            isr_q <= isr_d;
            imsk_q <= imsk_d;
            to_cnt_q <= to_cnt_d;
            fmal_q <= fmal_d;
            irq_q <= irq_d;
            abort_q <= ch.abort;
        end
    end

    // Zero wait states; hreadyout is a constant flop, hresp always OKAY
    logic rdy_q;
    logic resp_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdy_q <= 1'b1;
            resp_q <= 1'b0;
        end else begin
            rdy_q <= 1'b1;
            resp_q <= 1'b0;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = rdy_q;
    assign hresp = resp_q;
    assign chan_run = ch.run;
    assign chan_abort = abort_q;
    assign func_malformed = fmal_q;
    assign irq = irq_q;

    // =============================================
    // Checks
    a_parity_on_poison: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && rx_valid && rx_err[RX_POISON] |=> pci_q[PCI_PARITY_BIT])
        else $error("Poisoned packet did not set parity flag");
    a_internal_ones: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && rx_valid && rx_err[RX_INTERNAL] && !hdr_vld_q
        |=> hdr_vld_q && hdr_q[0] == HDR_ALL_ONES && hdr_q[3] == HDR_ALL_ONES)
        else $error("Internal error header not all ones");
    a_hdr_held: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && hdr_vld_q && !hdr_free |=> $stable(hdr_q))
        else $error("Logged header overwritten");
    a_rank_only_top: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && rx_valid && rx_err[RX_ECRC] && rx_err[RX_POISON]
        && !rx_err[RX_INTERNAL] && !rx_err[RX_OVERFLOW] && !aer_q[RX_POISON]
        && !cpl_timeout |=> aer_q[RX_ECRC] && !aer_q[RX_POISON])
        else $error("Lower ranked error not suppressed");
    a_timeout_count: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && cpl_timeout |=> to_cnt_q == $past(to_cnt_q) + CNT_W'(1))
        else $error("Timeout occurrence not counted");
    a_malf_all_func: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && port_malformed |=> &func_malformed)
        else $error("Malformed not recorded in every function");
    a_unclaimed_hdr: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && rx_valid && rx_err == 7'h10 && rx_on_up_link && !rx_claimed_any
        && !hdr_vld_q |=> hdr_vld_q && hdr_q[0] == $past(rx_hdr[31:0]))
        else $error("Unclaimed UR header not logged");
    a_poison_nolink: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && rx_valid && rx_err == 7'h40 && !rx_from_link && !hdr_vld_q
        && aer_q == 8'h0 |=> !hdr_vld_q)
        else $error("Header logged for packet not from link");
    a_ecrc_up_hdr: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && rx_valid && rx_err == 7'h04 && rx_on_up_link && !hdr_vld_q
        |=> hdr_vld_q && hdr_q[1] == $past(rx_hdr[63:32]))
        else $error("Upstream ECRC header not logged");
    a_claimed_ur_hdr: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && rx_valid && rx_err == 7'h10 && rx_claimed_dma && !hdr_vld_q
        |=> hdr_vld_q && hdr_q[2] == $past(rx_hdr[95:64]))
        else $error("Claimed UR header not logged");
    a_poison_hdr: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && rx_valid && rx_err == 7'h40 && rx_claimed_dma && rx_on_up_link
        && rx_from_link && !hdr_vld_q |=> hdr_vld_q)
        else $error("Claimed poisoned header not logged");
    // Frozen state must not drift, or a stalled core loses events
    a_ce_freeze: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !ce |=> $stable(aer_q) && $stable(to_cnt_q) && $stable(isr_q))
        else $error("State moved while clock enable low");
    a_irq_level: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce |=> irq == |(isr_q & imsk_q))
        else $error("Interrupt level disagrees with status");
    a_abort_irq: assert property (
        @(posedge core_clk) disable iff (!rstn)
        ce && |ch.abort |=> |isr_q[3:0])
        else $error("Channel abort did not raise status");
endmodule

// *** sim/far_link.sv ***
// Purpose: Link partner model for completions and received errors
// Assumes: Tasks are entered right after a rising core_clk edge
// Notes: Released qualifiers toggle so a stale value never looks valid
`timescale 1ns/100ps
module far_link (
    input wire logic core_clk,
    output logic cpl_valid,
    output logic cpl_expected,
    output logic cpl_is_desc,
    output logic [1:0] cpl_chan,
    output logic [2:0] cpl_status,
    output logic rx_valid,
    output logic [6:0] rx_err,
    output logic [127:0] rx_hdr,
    output logic rx_on_up_link,
    output logic rx_from_link,
    output logic rx_claimed_dma,
    output logic rx_claimed_any,
    output logic port_malformed,
    output logic cpl_timeout
);
    logic [127:0] junk = {16{8'ha5}};
    // ==========================================
    // Packet tasks
    task automatic idle();
        junk = ~junk;
        {cpl_expected, cpl_is_desc, cpl_chan, cpl_status} <= junk[6:0];
        {rx_err, rx_on_up_link, rx_from_link} <= junk[8:0];
        {rx_claimed_dma, rx_claimed_any} <= junk[1:0];
        rx_hdr <= junk;
    endtask
    task automatic cpl(input logic [1:0] ch, input logic d, input logic x,
                       input logic [2:0] s);
        cpl_valid <= 1'b1;
        {cpl_expected, cpl_is_desc, cpl_chan, cpl_status} <= {x, d, ch, s};
        @(posedge core_clk);
        cpl_valid <= 1'b0;
        idle();
    endtask
    task automatic rx(input logic [6:0] e, input logic [127:0] h,
                      input logic [3:0] q);
        {rx_valid, rx_err, rx_hdr} <= {1'b1, e, h};
        {rx_on_up_link, rx_from_link, rx_claimed_dma, rx_claimed_any} <= q;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        idle();
    endtask
    task automatic pulse(input logic tmo);
        if (tmo) cpl_timeout <= 1'b1;
        else port_malformed <= 1'b1;
        @(posedge core_clk);
        {cpl_timeout, port_malformed} <= 2'b00;
    endtask
    initial begin
        {cpl_valid, rx_valid, port_malformed, cpl_timeout} = 4'h0;
        idle();
    end
endmodule

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the DMA TLP error logger
// Assumes: Zero-wait AHB-Lite slave, single core clock
// Notes: Expected values come from a small integer model here
`timescale 1ns/100ps
module tb_top
    import dma_err_pkg::*;
;
    logic core_clk = 1'b0, rstn = 1'b0, ce = 1'b1, hsel = 1'b0;
    logic hwrite = 1'b0, hreadyout, hresp, irq, iq;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic [NUM_CH-1:0] chan_run, chan_abort;
    logic [NUM_FUNC-1:0] func_malformed;
    logic cpl_valid, cpl_expected, cpl_is_desc, rx_valid, rx_on_up_link;
    logic rx_from_link, rx_claimed_dma, rx_claimed_any, port_malformed;
    logic cpl_timeout;
    logic [1:0] cpl_chan;
    logic [2:0] cpl_status;
    logic [6:0] rx_err;
    logic [127:0] rx_hdr;
    int miscompares = 0, n_compared = 0, seed = 20948;
    always #5 core_clk = ~core_clk;
    dma_tlp_error_logger dma_tlp_error_logger_inst (.core_clk, .rstn, .ce,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .cpl_valid, .cpl_expected, .cpl_is_desc,
        .cpl_chan, .cpl_status, .rx_valid, .rx_err, .rx_hdr, .rx_on_up_link,
        .rx_from_link, .rx_claimed_dma, .rx_claimed_any, .port_malformed,
        .cpl_timeout, .chan_run, .chan_abort, .func_malformed, .irq);
    far_link far_link_inst (.core_clk, .cpl_valid, .cpl_expected,
        .cpl_is_desc, .cpl_chan, .cpl_status, .rx_valid, .rx_err, .rx_hdr,
        .rx_on_up_link, .rx_from_link, .rx_claimed_dma, .rx_claimed_any,
        .port_malformed, .cpl_timeout);
    // ==========================================
    // Checks and bus tasks
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Sample before the edge so registered outputs are settled
    // No wait limit here; only the watchdog ends a stuck transfer
    task automatic wait_rdy();
        logic r;
        do begin
            @(negedge core_clk);
            {r, q, iq} = {hreadyout, hrdata, irq};
            @(posedge core_clk);
        end while (r !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, w};
        wait_rdy();
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        wait_rdy();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
        bus(1'b0, a, 32'h0);
        chk(q, x, m);
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Whole run is near 520 cycles; allow about forty times that
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
    // ==========================================
    // Main sequence
    initial begin
        int k, t, lg;
        logic [1:0] ch;
        logic [7:0] co;
        logic [6:0] e;
        logic [3:0] qq;
        logic [127:0] h;
        logic [31:0] x;
        logic [7:0] regs[9] = '{8'h00, 8'h0c, OFS_AER_STS, OFS_HDR0,
            OFS_PCI_STS, OFS_IRQ_STS, OFS_IRQ_MSK, OFS_TO_CNT, 8'h40};
        int run = 0;
        repeat (7) @(posedge core_clk);
        @(negedge core_clk);
        chk(32'({hreadyout, hresp, irq, chan_run}), 32'h40, "reset outputs");
        @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        bus(1'b1, 8'h40, 32'hffffffff);
        foreach (regs[i]) rd(regs[i], 32'h0, "reset or unmapped");
        $display("test reset done");
        for (k = 0; k < 8; k++) begin
            ch = 2'($random(seed));
            t = k % 4;
            co = OFS_CH_ERR0 + {4'h0, ch, 2'b00};
            x = t[1] ? 32'(CPL_STS_CA) : 32'(CPL_STS_UR);
            bus(1'b1, OFS_CH_RUN, 32'h1 << ch);
            run = run | (1 << ch);
            far_link_inst.cpl(ch, ~t[0], 1'b0, x[2:0]);
            @(posedge core_clk);
            far_link_inst.cpl(ch + 2'h1, ~t[0], 1'b1, x[2:0]);
            @(posedge core_clk);
            rd(OFS_CH_RUN, run, "ignored completions");
            far_link_inst.cpl(ch, ~t[0], 1'b1, x[2:0]);
            run = run & ~(1 << ch);
            @(negedge core_clk);
            chk(32'({chan_abort, chan_run}), run, "run stop");
            @(negedge core_clk);
            chk(32'(chan_abort), 1 << ch, "abort pulse");
            @(negedge core_clk);
            chk(32'(chan_abort), 0, "abort end");
            @(posedge core_clk);
            rd(OFS_IRQ_STS, 32'h1 << ch, "irq status");
            chk(iq, 1'b0, "irq masked");
            bus(1'b1, OFS_IRQ_MSK, 32'h1 << ch);
            rd(co, 32'h1 << t, "chan flag");
            chk(iq, 1'b1, "irq raised");
            bus(1'b1, OFS_IRQ_STS, 32'h1 << ch);
            rd(co, 32'h1 << t, "flag sticky");
            bus(1'b1, co, 32'h1 << t);
            rd(co, 32'h0, "flag cleared");
            chk(iq, 1'b0, "irq cleared");
            bus(1'b1, OFS_IRQ_MSK, 32'h0);
        end
        $display("test completions done");
        far_link_inst.pulse(1'b0);
        @(negedge core_clk);
        chk(32'(func_malformed), (1 << NUM_FUNC) - 1, "all funcs");
        @(negedge core_clk);
        chk(32'(func_malformed), 0, "malformed pulse end");
        @(posedge core_clk);
        for (k = 0; k < 16; k++) begin
            bus(1'b1, OFS_AER_STS, 32'hff);
            bus(1'b1, OFS_PCI_STS, 32'h1 << PCI_PARITY_BIT);
            bus(1'b1, OFS_IRQ_STS, 32'h3f);
            e = 7'($random(seed));
            if (e[4] && e[5]) e[5] = 1'b0;
            if (e == 7'h0) e[6] = 1'b1;
            qq = 4'($random(seed));
            qq[2] = qq[2] | qq[3];
            qq[1] = qq[1] & qq[0];
            h = {$random(seed), $random(seed), $random(seed), $random(seed)};
            t = 0;
            while (!e[t]) t++;
            case (t)
                0: lg = 1;
                1: lg = 0;
                2, 3: lg = qq[3];
                4, 5: lg = (qq[3] & ~qq[0]) | qq[1];
                default: lg = qq[1] & qq[3] & qq[2];
            endcase
            far_link_inst.rx(e, h, qq);
            rd(OFS_AER_STS, 32'h1 << t, "ranked status");
            x = (t == 0) ? HDR_ALL_ONES : h[31:0];
            bus(1'b0, OFS_HDR0, 32'h0);
            if (lg) chk(q, x, "header w0");
            else chk(32'(q === h[31:0]), 32'h0, "no header");
            x = (t == 0) ? HDR_ALL_ONES : h[127:96];
            if (lg) rd(OFS_HDR0 + 8'h0c, x, "header w3");
            x = e[6] ? 32'h1 << PCI_PARITY_BIT : 32'h0;
            rd(OFS_PCI_STS, x, "parity flag");
            x = e[6] ? 32'h1 << IRQ_PARITY_BIT : 32'h0;
            rd(OFS_IRQ_STS, x | (32'h1 << IRQ_AER_BIT), "irq sts");
        end
        $display("test received errors done");
        bus(1'b1, OFS_AER_STS, 32'hff);
        far_link_inst.rx(7'h4, h, 4'hf);
        rd(OFS_TO_CNT, 32'h0, "no timeouts yet");
        far_link_inst.rx(7'h8, ~h, 4'hf);
        rd(OFS_HDR0, h[31:0], "first header kept");
        far_link_inst.pulse(1'b1);
        @(posedge core_clk);
        far_link_inst.pulse(1'b1);
        rd(OFS_TO_CNT, 32'h2, "every timeout");
        rd(OFS_AER_STS, 32'h8c, "timeout status");
        ce <= 1'b0;
        far_link_inst.pulse(1'b1);
        ce <= 1'b1;
        rd(OFS_TO_CNT, 32'h2, "frozen while ce low");
        $display("test header and timeout done");
        summarize();
    end
endmodule
